// ==== hdl/xio_cfg_pkg.sv ====
// Constants, field layout and decode helpers for the configuration word block.
// Assumes word addresses count 16-bit words and one word moves per link clock edge.
package xio_cfg_pkg;

  // Width of a 16-bit word address built from the command-address word.
  localparam int ADDR_W = 24;

  // Value loaded into the configuration word at reset.
  localparam logic [15:0] CONFIG_RESET = 16'h8f2f;

  // Field positions inside the configuration word.
  localparam int POWER_BIT  = 15;
  localparam int DRV_MSB    = 14;
  localparam int DRV_LSB    = 12;
  localparam int LAT_MSB    = 7;
  localparam int LAT_LSB    = 4;
  localparam int FIXED_BIT  = 3;
  localparam int HYBRID_BIT = 2;
  localparam int BLEN_MSB   = 1;
  localparam int BLEN_LSB   = 0;

  // Field positions inside the command-address word.
  localparam int CMD_RW_BIT    = 47;
  localparam int CMD_SPACE_BIT = 46;
  localparam int CMD_BURST_BIT = 45;

  // Register address bits that select the configuration word.
  localparam logic [39:0] CONFIG_REG_ADDR = 40'h0001000000;

  // Index of the last of the three command-address edges.
  localparam logic [1:0] CMD_LAST = 2'h2;

  // Data returned by a register read at an address that holds nothing.
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // Initial latency in link clocks; reserved codes fall back to seven.
  function automatic logic [3:0] latency_clocks(input logic [3:0] code);
    case (code)
      4'h0:    latency_clocks = 4'h5;
      4'h1:    latency_clocks = 4'h6;
      4'h2:    latency_clocks = 4'h7;
      4'he:    latency_clocks = 4'h3;
      4'hf:    latency_clocks = 4'h4;
      default: latency_clocks = 4'h7;
    endcase
  endfunction : latency_clocks

  // Latency in link edges, doubled when the extra refresh latency applies.
  function automatic logic [4:0] latency_edges(input logic [3:0] code, input logic dbl);
    latency_edges = dbl ? {latency_clocks(code), 1'b0} << 1 : {latency_clocks(code), 1'b0};
  endfunction : latency_edges

  // Wrap group size in 16-bit words for a burst length code.
  function automatic logic [7:0] wrap_words(input logic [1:0] code);
    case (code)
      2'h0:    wrap_words = 8'h80;
      2'h1:    wrap_words = 8'h40;
      2'h2:    wrap_words = 8'h10;
      default: wrap_words = 8'h20;
    endcase
  endfunction : wrap_words

  // First word address of a burst taken from row, half-page and column bits.
  function automatic logic [ADDR_W-1:0] start_word(input logic [47:0] ca);
    start_word = {ca[35:16], ca[2:0], 1'b0};
  endfunction : start_word

endpackage : xio_cfg_pkg

// ==== hdl/core_link_if.sv ====
// Interface joining the link controller, configuration word and burst sequencer.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ps
interface core_link_if;
  import xio_cfg_pkg::*;

  logic              wr_en;      // One-cycle load of the configuration word.
  logic [15:0]       wr_data;    // Word written by the host.
  logic              wake;       // One-cycle wake from deep power down.
  logic [15:0]       cfg;        // Current configuration word.
  logic              start;      // One-cycle burst start.
  logic [ADDR_W-1:0] start_addr; // First word of the burst.
  logic              wrapped;    // High when the burst type asks for a wrap.
  logic              step;       // One-cycle advance to the next word.
  logic [ADDR_W-1:0] addr;       // Current word address.

  modport reg_mp (input wr_en, wr_data, wake, output cfg);
  modport seq_mp (input start, start_addr, wrapped, step, cfg, output addr);
  modport ctl_mp (output wr_en, wr_data, wake, start, start_addr, wrapped, step,
                  input cfg, addr);
endinterface : core_link_if

// ==== hdl/config_word_reg.sv ====
// Configuration word storage with reset defaults and power down wake.
// Assumes write and wake strobes are one-cycle pulses on clk_i.
`timescale 1ns/1ps
module config_word_reg
  import xio_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Link to the controller.
  core_link_if.reg_mp link
);

  // A host write loads the whole word; a wake restores normal operation.
  // The wake is applied last so it wins over a write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.cfg <= CONFIG_RESET;
    end else begin
      if (link.wr_en) begin
        link.cfg <= link.wr_data;
      end
      if (link.wake) begin
        link.cfg[POWER_BIT] <= 1'b1;
      end
    end
  end

  // Reset always leaves the documented defaults behind.
  property p_default;
    @(posedge clk_i) rst_i |=> link.cfg == CONFIG_RESET;
  endproperty
  a_default : assert property (p_default) else $error("config default not loaded");

  // Leaving deep power down sets the control bit back by itself.
  property p_wake;
    @(posedge clk_i) disable iff (rst_i) link.wake |=> link.cfg[POWER_BIT];
  endproperty
  a_wake : assert property (p_wake) else $error("power down bit not restored");

endmodule : config_word_reg

// ==== hdl/burst_addr_seq.sv ====
// Word address sequencer for linear, legacy wrapped and hybrid bursts.
// Assumes start and step are one-cycle pulses and never coincide.
`timescale 1ns/1ps
module burst_addr_seq
  import xio_cfg_pkg::*;
#(
  parameter int AW = ADDR_W // Address width in words.
)(
  // Clock and reset.
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Link to the controller.
  core_link_if.seq_mp link
);

  // A wrap group of 128 words needs at least eight address bits.
  if (AW < 8 || AW != ADDR_W) begin : g_check
    $error("burst_addr_seq: unsupported address width");
  end

  logic [AW-1:0] addr;     // Current word address.
  logic [7:0]    len;      // Wrap group size latched at start.
  logic [7:0]    cnt;      // Words stepped inside the first wrap.
  logic          wrap;     // Burst is wrapped.
  logic          hyb;      // Hybrid sequence selected.
  logic          lin;      // Wrap finished, now linear.
  logic [AW-1:0] start_a;  // Start word kept for checking.

  wire [AW-1:0] mask    = {{(AW-8){1'b0}}, len - 8'h01};
  wire [AW-1:0] base    = addr & ~mask;
  wire [AW-1:0] inc     = AW'(addr + 1'b1);
  wire          wrap_end = cnt == len - 8'h01;
  wire [AW-1:0] next_addr =
    (!wrap || lin)  ? inc :
    (hyb && wrap_end) ? AW'(base + {{(AW-8){1'b0}}, len}) :
    base | (inc & mask);

  assign link.addr = addr;

  // Latches the burst shape at start, then walks the word sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr <= '0;
      len <= 8'h20;
      cnt <= 8'h00;
      wrap <= 1'b0;
      hyb <= 1'b0;
      lin <= 1'b0;
      start_a <= '0;
    end else if (link.start) begin
      addr <= link.start_addr;
      start_a <= link.start_addr;
      len <= wrap_words(link.cfg[BLEN_MSB:BLEN_LSB]);
      hyb <= ~link.cfg[HYBRID_BIT];
      wrap <= link.wrapped;
      cnt <= 8'h00;
      lin <= 1'b0;
    end else if (link.step) begin
      addr <= next_addr;
      if (wrap && !lin) begin
        cnt <= 8'(cnt + 8'h01);
        lin <= hyb && wrap_end;
      end
    end
  end

  // A wrapped step other than the hybrid jump never leaves its aligned group.
  property p_group;
    @(posedge clk_i) disable iff (rst_i)
      (link.step && wrap && !lin && !(hyb && wrap_end)) |=> (addr & ~mask) == $past(base);
  endproperty
  a_group : assert property (p_group) else $error("wrap left its group");

  // A legacy wrap is back at the start word after one full group.
  property p_wrap_home;
    @(posedge clk_i) disable iff (rst_i)
      (link.step && wrap && !hyb && cnt == len - 8'h01) |=> addr == start_a;
  endproperty
  a_wrap_home : assert property (p_wrap_home) else $error("wrap did not return home");

  // A hybrid burst jumps to the first word of the next group.
  property p_hybrid_jump;
    @(posedge clk_i) disable iff (rst_i)
      (link.step && wrap && hyb && !lin && wrap_end) |=> (addr == $past(base) + len) && lin;
  endproperty
  a_hybrid_jump : assert property (p_hybrid_jump) else $error("hybrid jump wrong");

  // A linear burst counts up regardless of the hybrid setting.
  property p_linear;
    @(posedge clk_i) disable iff (rst_i)
      (link.step && !wrap) |=> addr == AW'($past(addr) + 1'b1);
  endproperty
  a_linear : assert property (p_linear) else $error("linear step wrong");

  c_hybrid : cover property (@(posedge clk_i) link.step && wrap && hyb && wrap_end && !lin);

endmodule : burst_addr_seq

// ==== hdl/xio_cfg_burst.sv ====
// Device side of the memory bus: command capture, latency, configuration word
// access and burst addressing towards the memory array.
// Assumes the host link clock is slow against clk_i (at least four clk_i per edge),
// and that the array answers a read strobe with data one cycle later.
`timescale 1ns/1ps
module xio_cfg_burst
  import xio_cfg_pkg::*;
(
  // System clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Memory bus pins.
  input  wire logic              ck_i,
  input  wire logic              cs_n_i,
  input  wire logic [15:0]       dq_i,
  output logic      [15:0]       dq_o,
  output logic                   dq_oe_o,
  input  wire logic              read_write_strobe_i,
  output logic                   read_write_strobe_o,
  output logic                   read_write_strobe_oe_o,
  // Array refresh and power management.
  input  wire logic              refresh_needed_i,
  input  wire logic              deep_power_down_exit_i,
  // Memory array port.
  input  wire logic [15:0]       mem_rdata_i,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic      [15:0]       mem_wdata_o,
  output logic                   mem_mask_o,
  // Configuration outputs.
  output logic                   deep_power_down_o,
  output logic      [2:0]        drive_strength_o
);

  // Transaction phases as seen by the device.
  // Command edges, latency wait, register write data edge, read and array write data edges and the
  // dead phase after a register write that lasts until chip select rises.
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LAT, ST_WREG, ST_DATA, ST_DONE} state_type;

  core_link_if link ();

  logic [1:0]  ck_sync;   // Link clock synchroniser.
  logic [1:0]  cs_sync;   // Chip select synchroniser.
  logic [1:0]  strobe_sync; // Strobe synchroniser.
  logic [15:0] dq_meta;   // First stage of the data synchroniser.
  logic [15:0] dq_sync;   // Second stage of the data synchroniser.
  logic        ck_prev;   // Synchronised link clock one cycle late.
  state_type   state;     // Current transaction phase.
  logic [1:0]  cmd_cnt;   // Command edges taken so far.
  logic [47:0] cmd_word;  // Command-address word being assembled.
  logic [4:0]  lat_cnt;   // Latency edges still to wait.
  logic        dbl;       // Doubled latency for this transaction.
  logic        is_read;   // Transaction reads.
  logic        is_reg;    // Transaction targets register space.
  logic        reg_hit;   // Register address selects the configuration word.
  logic [1:0]  rd_pend;   // Read word on its way to the pins.

  // Decode of the link and the phase, shared by all processes below.
  wire        link_edge = ck_sync[1] ^ ck_prev;
  wire        cs_act    = ~cs_sync[1];
  // The command word shifts in most significant part first, one word per edge.
  wire [47:0] next_cmd  = {cmd_word[31:0], dq_sync};
  wire        cmd_done  = state == ST_CMD && link_edge && cmd_cnt == CMD_LAST;
  wire        ncmd_read = next_cmd[CMD_RW_BIT];
  wire        ncmd_reg  = next_cmd[CMD_SPACE_BIT];
  wire        ncmd_wreg = !ncmd_read && ncmd_reg;
  wire        ncmd_hit  = next_cmd[39:0] == CONFIG_REG_ADDR;
  wire        next_dbl  = link.cfg[FIXED_BIT] | refresh_needed_i;
  wire        data_edge = state == ST_DATA && link_edge;
  wire        wreg_edge = state == ST_WREG && link_edge;
  wire [4:0]  lat_load  = 5'(latency_edges(link.cfg[LAT_MSB:LAT_LSB], dbl) - 5'h01);

  // Requests to the configuration word and the burst sequencer.
  assign link.wr_en      = wreg_edge && reg_hit;
  assign link.wr_data    = dq_sync;
  assign link.wake       = deep_power_down_exit_i;
  assign link.start      = cmd_done;
  assign link.start_addr = start_word(next_cmd);
  assign link.wrapped    = ~next_cmd[CMD_BURST_BIT];
  assign link.step       = data_edge && !is_reg;

  config_word_reg u_cfg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .link  (link)
  );

  burst_addr_seq #(.AW(ADDR_W)) u_seq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .link  (link)
  );

  // Two flip-flops on every memory bus pin before any logic looks at it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_sync <= 2'h0;
      cs_sync <= 2'h3;
      strobe_sync <= 2'h0;
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      ck_prev <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[0], ck_i};
      cs_sync <= {cs_sync[0], cs_n_i};
      strobe_sync <= {strobe_sync[0], read_write_strobe_i};
      dq_meta <= dq_i;
      dq_sync <= dq_meta;
      ck_prev <= ck_sync[1];
    end
  end

  // Phase sequence; chip select going high ends any transaction at once.
  // In deep power down the device stays idle and ignores the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (link.cfg[POWER_BIT]) begin
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cmd_done) begin
            state <= ncmd_wreg ? ST_WREG : ST_LAT;
          end
        end
        ST_LAT: begin
          if (link_edge && lat_cnt == 5'h00) begin
            state <= ST_DATA;
          end
        end
        ST_WREG: begin
          if (link_edge) begin
            state <= ST_DONE;
          end
        end
        ST_DATA: begin
          state <= ST_DATA;
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
      endcase
    end
  end

  // Command capture and latency count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_cnt <= 2'h0;
      cmd_word <= 48'h000000000000;
      lat_cnt <= 5'h00;
      dbl <= 1'b0;
      is_read <= 1'b0;
      is_reg <= 1'b0;
      reg_hit <= 1'b0;
    end else begin
      if (state == ST_IDLE) begin
        cmd_cnt <= 2'h0;
        dbl <= next_dbl;
      end
      if (state == ST_CMD && link_edge) begin
        cmd_word <= next_cmd;
        cmd_cnt <= 2'(cmd_cnt + 2'h1);
      end
      if (cmd_done) begin
        is_read <= ncmd_read;
        is_reg <= ncmd_reg;
        reg_hit <= ncmd_hit;
        lat_cnt <= lat_load;
      end else if (state == ST_LAT && link_edge) begin
        lat_cnt <= 5'(lat_cnt - 5'h01);
      end
    end
  end

  // Pin drivers: the strobe flags doubled latency (fixed or refresh) during the command,
  // then marks each read word by toggling.
  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      read_write_strobe_oe_o <= 1'b0;
      read_write_strobe_o <= 1'b0;
      dq_oe_o <= 1'b0;
      dq_o <= 16'h0000;
    end else if (state == ST_IDLE) begin
      read_write_strobe_oe_o <= link.cfg[POWER_BIT];
      read_write_strobe_o <= next_dbl;
    end else if (cmd_done) begin
      // Writes release the strobe; the host never masks a register word.
      read_write_strobe_oe_o <= ncmd_read;
      read_write_strobe_o <= 1'b0;
    end else if (rd_pend[1]) begin
      dq_oe_o <= 1'b1;
      dq_o <= !is_reg ? mem_rdata_i : reg_hit ? link.cfg : UNMAPPED_READ;
      read_write_strobe_o <= ~read_write_strobe_o;
    end
  end

  // Array strobes and the registered configuration outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pend <= 2'h0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 16'h0000;
      mem_mask_o <= 1'b0;
      deep_power_down_o <= 1'b0;
      drive_strength_o <= 3'h0;
    end else begin
      rd_pend <= {rd_pend[0], data_edge && is_read};
      mem_rd_o <= link.step && is_read;
      mem_wr_o <= link.step && !is_read;
      mem_addr_o <= link.addr;
      mem_wdata_o <= dq_sync;
      mem_mask_o <= strobe_sync[1];
      deep_power_down_o <= ~link.cfg[POWER_BIT];
      drive_strength_o <= link.cfg[DRV_MSB:DRV_LSB];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A transaction may only begin while the device is awake and selected.
  wire txn_begin = state == ST_IDLE && cs_act && link.cfg[POWER_BIT];

  // Fixed latency always shows doubled latency on the strobe.
  property p_fixed_flag;
    (txn_begin && link.cfg[FIXED_BIT]) |=> dbl && read_write_strobe_oe_o && read_write_strobe_o;
  endproperty
  a_fixed_flag : assert property (p_fixed_flag) else $error("fixed latency not flagged");

  // Variable latency without refresh keeps single latency.
  property p_var_single;
    (txn_begin && !link.cfg[FIXED_BIT] && !refresh_needed_i) |=>
      !dbl && read_write_strobe_oe_o && !read_write_strobe_o;
  endproperty
  a_var_single : assert property (p_var_single) else $error("variable latency doubled");

  // Variable latency with a pending refresh flags the extra latency.
  property p_var_double;
    (txn_begin && !link.cfg[FIXED_BIT] && refresh_needed_i) |=>
      dbl && read_write_strobe_oe_o && read_write_strobe_o;
  endproperty
  a_var_double : assert property (p_var_double) else $error("refresh latency not flagged");

  // Latency count matches the code and the doubling.
  property p_lat_load;
    (cmd_done && !ncmd_wreg) |=> state == ST_LAT && lat_cnt == lat_load;
  endproperty
  a_lat_load : assert property (p_lat_load) else $error("latency count wrong");

  // Register write data lands whole in the configuration word.
  property p_reg_write;
    (wreg_edge && reg_hit && !deep_power_down_exit_i) |=> link.cfg == $past(dq_sync);
  endproperty
  a_reg_write : assert property (p_reg_write) else $error("register write lost");

  // A write command leaves the strobe to the host side, where it serves as the array write mask.
  property p_write_release;
    (cmd_done && !ncmd_read) |=> !read_write_strobe_oe_o;
  endproperty
  a_write_release : assert property (p_write_release) else $error("strobe kept on write");

  // Clearing the power bit raises the deep power down output.
  property p_power_enter;
    $fell(link.cfg[POWER_BIT]) |=> deep_power_down_o;
  endproperty
  a_power_enter : assert property (p_power_enter) else $error("deep power down missed");

  // While asleep the device ignores chip select and stays idle.
  property p_power_quiet;
    (state == ST_IDLE && !link.cfg[POWER_BIT]) |=> state == ST_IDLE;
  endproperty
  a_power_quiet : assert property (p_power_quiet) else $error("bus taken while asleep");

  c_reg_write : cover property (wreg_edge && reg_hit);
  c_array_read : cover property (rd_pend[1] && !is_reg);
  c_power_down : cover property ($fell(link.cfg[POWER_BIT]));

endmodule : xio_cfg_burst

// ==== testbench/host_bus_model.sv ====
// Host side of the memory bus: frames commands, counts latency and captures read words.
// Assumes clk_i is the device system clock; each link half period lasts four clk_i.
`timescale 1ns/1ps
module host_bus_model (
  // System clock.
  input  wire logic        clk_i,
  // Pin levels seen by the device.
  output logic             ck_o,
  output logic             cs_n_o,
  output logic [15:0]      dq_o,
  output logic             strobe_o,
  // Device pin drivers.
  input  wire logic [15:0] dev_dq_i,
  input  wire logic        dev_dq_oe_i,
  input  wire logic        dev_strobe_i,
  input  wire logic        dev_strobe_oe_i
);
  logic [15:0] drv;        // Last word put on the bus.
  logic        oe;         // High while the host drives dq.
  logic        strobe;     // Strobe level seen in the command phase.
  logic [15:0] rd [256];   // Captured read words.

  // A released line shows the inverse of its last value, never a stale copy.
  assign dq_o   = oe ? drv : (dev_dq_oe_i ? dev_dq_i : ~drv);
  // The host never drives the strobe itself.
  assign strobe_o = dev_strobe_oe_i ? dev_strobe_i : ~dev_strobe_i;

  // Link clock idles low and the device starts deselected.
  initial begin
    ck_o = 1'b0;
    cs_n_o = 1'b1;
    drv = 16'h0000;
    oe = 1'b0;
    strobe = 1'b0;
  end

  // Waits n falling edges of the system clock.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // One link edge carrying word w, with data set up and held two cycles.
  task automatic put(input logic [15:0] w);
    drv = w;
    oe = 1'b1;
    tick(2);
    ck_o = ~ck_o;
    tick(2);
  endtask : put

  // Command phase: three edges, most significant bits first.
  task automatic cmd(input logic [47:0] cw);
    cs_n_o = 1'b0;
    tick(4);
    put(cw[47:32]);
    put(cw[31:16]);
    strobe = strobe_o;
    put(cw[15:0]);
    oe = 1'b0;
  endtask : cmd

  // Ends the frame with the link clock low, then keeps the gap between frames.
  task automatic close();
    oe = 1'b0;
    if (ck_o) begin
      tick(4);
      ck_o = 1'b0;
    end
    tick(4);
    cs_n_o = 1'b1;
    tick(6);
  endtask : close

  // Register write: one whole word right after the command, no latency.
  task automatic wreg(input logic [47:0] cw, input logic [15:0] w);
    cmd(cw);
    put(w);
    close();
  endtask : wreg

  // Read: latency doubled when the strobe was high, then n words sampled late.
  task automatic read(input logic [47:0] cw, input int clocks, input int n);
    cmd(cw);
    repeat (2 * clocks * (strobe ? 2 : 1)) begin
      ck_o = ~ck_o;
      tick(4);
    end
    for (int i = 0; i <= n; i++) begin
      if (i < n) ck_o = ~ck_o;
      tick(3);
      if (i > 0) rd[i-1] = dq_o;
      tick(1);
    end
    close();
  endtask : read
endmodule : host_bus_model

// ==== testbench/config_reg_burst_control_test.sv ====
// Self-checking bench for the configuration word and burst sequencing.
// Assumes the host model and a one-cycle array model stand beside the device.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module config_reg_burst_control_test;
  import xio_cfg_pkg::*;
  localparam logic [47:0] CFG_WR = 48'h600001000000; // Config word write.
  localparam logic [47:0] CFG_RD = 48'hc00001000000; // Config word read.
  logic              clk_i, rst_i, refresh_needed_i, wake_i, oe_seen;
  logic              ck, cs_n, strb, dq_oe, strb_o, strb_oe, mem_rd, mem_wr, power_o;
  logic [15:0]       dq, dq_o, mem_rdata, cfg, mem_wdata, wr_word;
  logic [ADDR_W-1:0] mem_addr, wr_addr;
  logic [2:0]        drive_o;
  int                error_cnt, total_checks;

  xio_cfg_burst dut (.clk_i(clk_i), .rst_i(rst_i), .ck_i(ck), .cs_n_i(cs_n), .dq_i(dq),
    .dq_o(dq_o), .dq_oe_o(dq_oe), .read_write_strobe_i(strb), .read_write_strobe_o(strb_o),
    .read_write_strobe_oe_o(strb_oe), .refresh_needed_i(refresh_needed_i),
    .deep_power_down_exit_i(wake_i), .mem_rdata_i(mem_rdata), .mem_addr_o(mem_addr),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .mem_mask_o(),
    .deep_power_down_o(power_o), .drive_strength_o(drive_o));
  host_bus_model host (.clk_i(clk_i), .ck_o(ck), .cs_n_o(cs_n), .dq_o(dq), .strobe_o(strb),
    .dev_dq_i(dq_o), .dev_dq_oe_i(dq_oe), .dev_strobe_i(strb_o), .dev_strobe_oe_i(strb_oe));
  // Array keeps the last word written and where it went.
  always @(posedge clk_i) if (mem_wr) begin wr_word <= mem_wdata; wr_addr <= mem_addr; end

  // Array answers a read strobe one cycle later with a word keyed by its address.
  always @(posedge clk_i) if (mem_rd) mem_rdata <= mem_addr[15:0] ^ 16'h5a00;
  // Notes any cycle in which the device drives the data pins.
  always @(posedge clk_i) if (dq_oe) oe_seen <= 1'b1;

  // Latency clocks for each legal code.
  function automatic int lat(input logic [3:0] c);
    case (c)
      4'h0: lat = 5;
      4'h1: lat = 6;
      4'he: lat = 3;
      4'hf: lat = 4;
      default: lat = 7;
    endcase
  endfunction : lat

  // Word address of beat i; mode 0 linear, 1 legacy wrap, 2 hybrid.
  function automatic logic [15:0] beat(input int s, input int len, input int m, input int i);
    int base;
    base = s - s % len;
    if (m == 0) beat = 16'(s + i);
    else if (m == 2 && i >= len) beat = 16'(base + i);
    else beat = 16'(base + (s - base + i) % len);
  endfunction : beat

  // Writes the config word and tracks it.
  task automatic set_cfg(input logic [15:0] v);
    host.wreg(CFG_WR, v);
    cfg = v;
  endtask : set_cfg

  // Defaults after reset, fixed latency flagged and doubled.
  task automatic t_reset();
    host.read(CFG_RD, 7, 1);
    `CHK("reset strobe", 1'b1, host.strobe)
    `CHK("reset word", 16'h8f2f, host.rd[0])
    `CHK("reset drive", 3'h0, drive_o)
    `CHK("reset power", 1'b0, power_o)
  endtask : t_reset

  // Every legal latency code under variable latency, with and without refresh.
  task automatic t_latency();
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'he, 4'hf};
    foreach (codes[k]) for (int r = 0; r < 2; r++) begin
      set_cfg({1'b1, codes[k][2:0], 4'hf, codes[k], 4'h7});
      refresh_needed_i = r[0];
      host.read(48'ha00000010000, lat(codes[k]), 2);
      `CHK("variable strobe", r[0], host.strobe)
      `CHK("first word", 16'h5a10, host.rd[0])
      `CHK("second word", 16'h5a11, host.rd[1])
      `CHK("drive field", codes[k][2:0], drive_o)
    end
    refresh_needed_i = 1'b0;
  endtask : t_latency

  // Each burst length in linear, legacy wrap and hybrid order from word 2e.
  task automatic t_bursts();
    int len;
    for (int b = 0; b < 4; b++) for (int m = 0; m < 3; m++) begin
      len = b == 0 ? 128 : b == 1 ? 64 : b == 2 ? 16 : 32;
      set_cfg({12'h8f2, 1'b0, m == 1, b[1:0]});
      host.read({m == 0 ? 8'ha0 : 8'h80, 4'h0, 20'h00002, 13'h0000, 3'h7}, 7, len + 4);
      for (int i = 0; i < len + 4; i++) begin
        `CHK("burst beat", beat('h2e, len, m, i) ^ 16'h5a00, host.rd[i])
      end
    end
  endtask : t_bursts

  // Power down entry, refused access, and wake setting the bit again.
  task automatic t_power_down();
    set_cfg(16'h0f2f);
    `CHK("enter power down", 1'b1, power_o)
    oe_seen = 1'b0;
    host.read(CFG_RD, 7, 1);
    `CHK("quiet while down", 1'b0, oe_seen)
    wake_i = 1'b1;
    host.tick(1);
    wake_i = 1'b0;
    host.tick(3);
    `CHK("leave power down", 1'b0, power_o)
    cfg = 16'h8f2f;
    host.read(CFG_RD, 7, 1);
    `CHK("bit set on wake", 16'h8f2f, host.rd[0])
  endtask : t_power_down

  // One linear array write word; the released data lines show the inverse of the
  // last command word, so the array must receive ffff at word 10.
  task automatic t_array_write();
    host.read(48'h200000010000, 7, 1);
    `CHK("write word", 16'hffff, wr_word)
    `CHK("write addr", 24'h000010, wr_addr)
  endtask : t_array_write

  // Register commands at an empty address, then the other read command.
  task automatic t_unmapped();
    host.wreg(48'h600001000001, 16'h1234);
    host.read(48'hc00001000001, 7, 1);
    `CHK("empty read", 16'h0000, host.rd[0])
    host.read(48'he00001000000, 7, 1);
    `CHK("config kept", cfg, host.rd[0])
  endtask : t_unmapped

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // 40 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    refresh_needed_i = 1'b0;
    wake_i = 1'b0;
    oe_seen = 1'b0;
    mem_rdata = 16'h0000;
    wr_word = 16'h0000;
    wr_addr = '0;
    cfg = 16'h8f2f;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    host.tick(4);
    t_reset();
    t_latency();
    t_bursts();
    t_power_down();
    t_unmapped();
    t_array_write();
    conclude();
  end

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
endmodule : config_reg_burst_control_test
